// file: rtl/swt_watch_timer.sv
// subclock watch interval timer with apb register slave
`timescale 1ns/1ps
module swt_watch_timer
  import swt_pkg::*;
#(
  parameter int CNT_W = SWT_CNT_W
)
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // subclock pin and system events
  input wire logic sclk_in,
  input wire logic stop_req,
  // watchdog side
  input wire logic [1:0] wd_tap_sel,
  input wire logic timebase_clk,
  output logic wd_clk,
  output logic osc_wait_clk,
  // interrupts
  output logic interval_req,
  output logic irq
);

  typedef struct packed {
    logic [2:0] sync;
    logic [CNT_W-1:0] cnt;
    logic flag;
    logic ie;
    logic watchdog_clock_select;
    logic [SWT_SEL_W-1:0] sel;
    logic settled;
    logic stop;
    logic [SWT_EV_W-1:0] sts;
    logic [SWT_EV_W-1:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic req;
    logic irq;
    logic osc;
    logic wd;
  } swt_state_t;

  swt_state_t s_q;
  swt_state_t s_d;

  logic tick;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] carry;
  logic intv_evt;
  logic settle_evt;
  logic stop_entry;
  logic setup;
  logic wr;
  logic wr_ctrl;
  logic sw_clr;

  function automatic logic wd_tap(input logic [CNT_W-1:0] c,
                                  input logic [1:0] s);
    unique case (s)
      2'h0: wd_tap = c[SWT_WD_TAP0];
      2'h1: wd_tap = c[SWT_WD_TAP1];
      2'h2: wd_tap = c[SWT_WD_TAP2];
      2'h3: wd_tap = c[SWT_WD_TAP3];
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == SWT_ADDR_CTRL) || (a == SWT_ADDR_STS) ||
              (a == SWT_ADDR_MASK) || (a == SWT_ADDR_CNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event decode

  // sync[0] feeds only sync[1]; the edge is taken between sync[1] and sync[2]
  assign tick = s_q.sync[1] & ~s_q.sync[2];
  assign cnt_inc = s_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  // a bit carries out when it falls on an increment
  assign carry = tick ? (s_q.cnt & ~cnt_inc) : '0;
  assign intv_evt = carry[SWT_INTV_BASE + int'(s_q.sel)];
  assign settle_evt = ~s_q.settled & carry[SWT_SETTLE_BIT];
  assign stop_entry = stop_req & ~s_q.stop;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & s_q.ready & ~s_q.err;
  assign wr_ctrl = wr && (paddr == SWT_ADDR_CTRL);
  assign sw_clr = wr_ctrl & ~pwdata[SWT_B_CLR];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], sclk_in};
    s_d.stop = stop_req;
    // counter
    if (tick)
    begin
      s_d.cnt = cnt_inc;
    end
    if (sw_clr || stop_entry)
    begin
      s_d.cnt = '0;
    end
    // control fields
    if (wr_ctrl)
    begin
      s_d.watchdog_clock_select = pwdata[SWT_B_WATCHDOG_CLOCK_SELECT];
      s_d.ie = pwdata[SWT_B_IE];
      s_d.sel = pwdata[SWT_SEL_W-1:0];
      if (!pwdata[SWT_B_FLAG])
      begin
        s_d.flag = 1'b0;
      end
    end
    // a carry in the cycle of a software clear still sets the flag
    if (intv_evt)
    begin
      s_d.flag = 1'b1;
    end
    if (stop_entry)
    begin
      s_d.flag = 1'b0;
      s_d.settled = 1'b0;
    end
    else if (settle_evt)
    begin
      s_d.settled = 1'b1;
    end
    // sticky status, write one to clear, set wins
    if (wr && (paddr == SWT_ADDR_STS))
    begin
      s_d.sts = s_q.sts & ~pwdata[SWT_EV_W-1:0];
    end
    if (wr && (paddr == SWT_ADDR_MASK))
    begin
      s_d.mask = pwdata[SWT_EV_W-1:0];
    end
    s_d.sts[SWT_EV_INTV] = s_d.sts[SWT_EV_INTV] | intv_evt;
    s_d.sts[SWT_EV_SETTLE] = s_d.sts[SWT_EV_SETTLE] | settle_evt;
    // apb: data and answer prepared in the setup cycle, no wait state
    s_d.ready = setup;
    s_d.err = setup & ~addr_ok(paddr);
    s_d.rdata = '0;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        SWT_ADDR_CTRL:
        begin
          s_d.rdata[SWT_B_WATCHDOG_CLOCK_SELECT] = s_q.watchdog_clock_select;
          s_d.rdata[SWT_B_SETTLED] = s_q.settled;
          s_d.rdata[SWT_B_IE] = s_q.ie;
          s_d.rdata[SWT_B_FLAG] = s_q.flag;
          s_d.rdata[SWT_B_CLR] = 1'b1;
          s_d.rdata[SWT_SEL_W-1:0] = s_q.sel;
        end
        SWT_ADDR_STS: s_d.rdata[SWT_EV_W-1:0] = s_q.sts;
        SWT_ADDR_MASK: s_d.rdata[SWT_EV_W-1:0] = s_q.mask;
        SWT_ADDR_CNT: s_d.rdata[CNT_W-1:0] = s_q.cnt;
        default: s_d.rdata = '0;
      endcase
    end
    // outputs: req changes in the same cycle as flag and ie, the others one register late against their cause
    s_d.req = s_d.flag & s_d.ie;
    s_d.irq = |(s_q.sts & s_q.mask);
    s_d.osc = s_q.cnt[SWT_OSC_TAP];
    // both sources are async to each other; software must clear the dog
    s_d.wd = s_q.watchdog_clock_select ? timebase_clk : wd_tap(s_q.cnt, wd_tap_sel);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.sel <= SWT_SEL_RST;
      s_q.sts <= SWT_EV_RST;
      s_q.mask <= SWT_EV_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign interval_req = s_q.req;
  assign irq = s_q.irq;
  assign osc_wait_clk = s_q.osc;
  assign wd_clk = s_q.wd;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CNT_STEP: assert property (
    tick && !sw_clr && !stop_entry |=>
      s_q.cnt == $past(s_q.cnt) + {{(CNT_W-1){1'b0}}, 1'b1})
    else $error("counter did not step on a subclock edge");

  AST_CNT_HOLD: assert property (
    !tick && !sw_clr && !stop_entry |=> $stable(s_q.cnt))
    else $error("counter moved without a subclock edge");

  AST_FLAG_SET: assert property (
    intv_evt && !stop_entry |=> s_q.flag && s_q.sts[SWT_EV_INTV])
    else $error("interval carry did not set the flag");

  AST_REQ: assert property (
    interval_req == (s_q.flag && s_q.ie))
    else $error("request does not follow flag and enable");

  AST_FLAG_CLR: assert property (
    wr_ctrl && !pwdata[SWT_B_FLAG] && !intv_evt |=> !s_q.flag && !interval_req)
    else $error("writing zero did not clear the flag");

  // a set flag only goes away by a zero write or by stop entry
  AST_FLAG_HOLD: assert property (
    s_q.flag && !(wr_ctrl && !pwdata[SWT_B_FLAG]) && !stop_entry |=>
      s_q.flag)
    else $error("interval flag dropped on its own");

  AST_SW_CLR: assert property (
    sw_clr |=> s_q.cnt == '0)
    else $error("clear bit did not zero the counter");

  AST_CLR_READ: assert property (
    setup && !pwrite && paddr == SWT_ADDR_CTRL |=> prdata[SWT_B_CLR] && pready)
    else $error("clear bit did not read as one");

  AST_STOP: assert property (
    stop_entry |=> s_q.cnt == '0 && !s_q.flag && !s_q.settled)
    else $error("stop entry did not clear counter and flag");

  AST_SETTLE: assert property (
    settle_evt && !stop_entry |=> s_q.settled [*2])
    else $error("settled bit not set after the wait");

  AST_WD_SRC: assert property (
    s_q.watchdog_clock_select |=> wd_clk == $past(timebase_clk))
    else $error("watchdog clock not from timebase");

  AST_WD_TAP: assert property (
    !s_q.watchdog_clock_select |=> wd_clk == $past(wd_tap(s_q.cnt, wd_tap_sel)))
    else $error("watchdog clock not from the selected tap");

  AST_OSC_TAP: assert property (
    osc_wait_clk == $past(s_q.cnt[SWT_OSC_TAP]))
    else $error("wait timer clock not from its tap");

  AST_SEL_WR: assert property (
    wr_ctrl |=> s_q.sel == $past(pwdata[SWT_SEL_W-1:0]))
    else $error("interval code not taken from the write");

  AST_NO_REQ: assert property (
    !s_q.ie |-> !interval_req)
    else $error("request raised with the enable off");

  // once the wait is over only stop entry restarts it
  AST_SETTLED_HOLD: assert property (
    s_q.settled && !stop_entry |=> s_q.settled)
    else $error("settled bit dropped without stop entry");

  AST_IRQ: assert property (
    irq == |($past(s_q.sts) & $past(s_q.mask)))
    else $error("irq does not follow status and mask");

  // zero wait states: the answer always lands one edge after setup
  AST_READY: assert property (
    pready == $past(setup))
    else $error("pready not one cycle after setup");

  AST_ERR: assert property (
    setup && !addr_ok(paddr) |=> pready && pslverr && prdata == '0)
    else $error("unmapped access not refused");

  // a refused write must leave every control field alone
  AST_BAD_WR: assert property (
    psel && penable && pwrite && pready && pslverr |=>
      $stable({s_q.watchdog_clock_select, s_q.ie, s_q.sel, s_q.mask}))
    else $error("refused write changed a register");

endmodule

// file: rtl/swt_pkg.sv
// constants, register map and field layout of the subclock watch timer
//
// Contract
// - 15-bit free-running up counter, one step per subclock cycle, wraps.
// - counter always runs from the subclock, whatever the machine clock is; here it is a pclk register and stops with pclk.
// - 3-bit interval select picks 2^8 to 2^15 subclock cycles.
// - interval flag sets when the selected counter bit carries out.
// - request raised while interval flag and interval enable are both 1.
// - writing 0 to the flag clears it; writing 1 does nothing.
// - writing 0 to the clear bit zeroes the counter; it reads as 1.
// - watchdog clock select: 0 gives watch tap, 1 gives timebase output.
// - settled bit reads 0 during the 2^14-cycle wait, 1 after it.
// - taps: 2^14 to the wait timer; 2^10/2^13/2^14/2^15 to the watchdog.
// - request drives one fixed vector, never an automatic service transfer.
// - counter clears on power-on reset, stop-mode entry and software clear.
// - stop-mode entry clears the interval flag at the same moment.
package swt_pkg;
  // apb byte addresses
  localparam logic [7:0] SWT_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SWT_ADDR_STS = 8'h04;
  localparam logic [7:0] SWT_ADDR_MASK = 8'h08;
  localparam logic [7:0] SWT_ADDR_CNT = 8'h0c;
  // watch_ctrl_reg field positions
  localparam int SWT_B_WATCHDOG_CLOCK_SELECT = 7;
  localparam int SWT_B_SETTLED = 6;
  localparam int SWT_B_IE = 5;
  localparam int SWT_B_FLAG = 4;
  localparam int SWT_B_CLR = 3;
  localparam int SWT_SEL_W = 3;
  // status / mask bits
  localparam int SWT_EV_INTV = 0;
  localparam int SWT_EV_SETTLE = 1;
  localparam int SWT_EV_W = 2;
  // counter geometry
  localparam int SWT_CNT_W = 15;
  localparam int SWT_INTV_BASE = 7;   // code 0 -> bit 7 carries every 2^8
  localparam int SWT_SETTLE_BIT = 13; // carry of bit 13 = 2^14 cycles
  localparam int SWT_OSC_TAP = 13;    // square wave of period 2^14
  localparam int SWT_WD_TAP0 = 9;     // periods 2^10
  localparam int SWT_WD_TAP1 = 12;    // 2^13
  localparam int SWT_WD_TAP2 = 13;    // 2^14
  localparam int SWT_WD_TAP3 = 14;    // 2^15
  // reset values
  localparam logic [SWT_SEL_W-1:0] SWT_SEL_RST = 3'h0;
  localparam logic [SWT_EV_W-1:0] SWT_EV_RST = 2'h0;
endpackage

// file: dv/swt_far_model.sv
// far side: timebase source for the watchdog, and interrupt controller
`timescale 1ns/1ps
module swt_far_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from the timer, and the watchdog clear from the bench
  input wire logic irq,
  input wire logic wd_clk,
  input wire logic wd_clear,
  // to the timer, and the event counts to the bench
  output logic timebase_clk,
  output logic [1:0] wd_tap_sel,
  output int irq_count,
  output int wd_count
);
  logic irq_q;
  logic wd_q;
  logic [5:0] tb_q;
  assign wd_tap_sel = 2'h0;
  assign timebase_clk = tb_q[5];
  // one fixed vector: every rising request is one normal service
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
      tb_q <= 6'h0;
      irq_count <= 0;
      wd_q <= 1'b0;
      wd_count <= 0;
    end
    else
    begin
      irq_q <= irq;
      wd_q <= wd_clk;
      // watchdog: counts clock edges, software clears it
      if (wd_clear)
        wd_count <= 0;
      else if (wd_clk && !wd_q)
        wd_count <= wd_count + 1;
      tb_q <= tb_q + 6'h1;
      if (irq && !irq_q)
        irq_count <= irq_count + 1;
    end
  end
endmodule

// file: dv/testbench.sv
// self-checking bench for the watch timer over apb
`timescale 1ns/1ps
module testbench;
  import swt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sclk_in, stop_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, timebase_clk, wd_clk, osc_wait_clk;
  logic interval_req, irq, e, wd_clear;
  int wd_count;
  logic [1:0] wd_tap_sel;
  logic [2:0] sdiv;
  int errors, samples_checked, irq_count, n;
  swt_watch_timer u_swt_watch_timer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_in(sclk_in), .stop_req(stop_req), .wd_tap_sel(wd_tap_sel),
    .timebase_clk(timebase_clk), .wd_clk(wd_clk),
    .osc_wait_clk(osc_wait_clk), .interval_req(interval_req), .irq(irq));
  swt_far_model u_swt_far_model (.pclk(pclk), .presetn(presetn),
    .irq(irq), .wd_clk(wd_clk), .wd_clear(wd_clear),
    .timebase_clk(timebase_clk), .wd_tap_sel(wd_tap_sel),
    .irq_count(irq_count), .wd_count(wd_count));
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // subclock: 3 pclk high, 3 low, so each phase spans all three sync stages
  always @(posedge pclk)
  begin
    sdiv <= (sdiv == 3'h2) ? 3'h0 : sdiv + 3'h1;
    if (sdiv == 3'h2)
      sclk_in <= ~sclk_in;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] ex, got);
    samples_checked++;
    if (got !== ex)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the release reach an edge before the next request
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    cmp(nm, ex, r);
  endtask
  task automatic wait_clk(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    wait_clk(30000);
    errors++;
    wrap_up();
  end
  initial
  begin
    {psel, penable, pwrite, stop_req, sclk_in, presetn, wd_clear} = 7'h0;
    {paddr, pwdata, sdiv} = 43'h0;
    errors = 0;
    samples_checked = 0;
    wait_clk(3);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("ctrl_rst", SWT_ADDR_CTRL, 32'h08);
    apb(1'b0, 8'h10, 32'h0);
    cmp("unmapped_err", 32'h1, {31'h0, e});
    wr(SWT_ADDR_MASK, 32'h1);
    wr(SWT_ADDR_CTRL, 32'h20);
    apb(1'b0, SWT_ADDR_CNT, 32'h0);
    cmp("cnt_cleared", 32'h0, {31'h0, r > 32'h3});
    wait_clk(1300);
    rd("flag_early", SWT_ADDR_CTRL, 32'h28);
    for (int i = 0; i < 400 && interval_req !== 1'b1; i++)
      @(posedge pclk);
    cmp("interval_req", 32'h1, {31'h0, interval_req});
    rd("flag_set", SWT_ADDR_CTRL, 32'h38);
    rd("status", SWT_ADDR_STS, 32'h1);
    cmp("irq_on", 32'h1, {31'h0, irq});
    cmp("irq_count", 32'h1, irq_count);
    wr(SWT_ADDR_STS, 32'h1);
    wait_clk(2);
    cmp("irq_off", 32'h0, {31'h0, irq});
    wr(SWT_ADDR_CTRL, 32'h2f);
    wait_clk(2);
    cmp("req_cleared", 32'h0, {31'h0, interval_req});
    rd("code7", SWT_ADDR_CTRL, 32'h2f);
    wd_clear <= 1'b1;
    wait_clk(1);
    wd_clear <= 1'b0;
    wr(SWT_ADDR_CTRL, 32'h88);
    wd_clear <= 1'b1;
    wait_clk(1);
    wd_clear <= 1'b0;
    wait_clk(140);
    cmp("wd_edges", 32'h1, {31'h0, wd_count >= 2});
    rd("watchdog_clock_select", SWT_ADDR_CTRL, 32'h88);
    wr(SWT_ADDR_CTRL, 32'h00);
    wait_clk(1700);
    rd("flag_no_ie", SWT_ADDR_CTRL, 32'h18);
    cmp("req_masked", 32'h0, {31'h0, interval_req});
    stop_req <= 1'b1;
    wait_clk(3);
    stop_req <= 1'b0;
    rd("flag_stop", SWT_ADDR_CTRL, 32'h08);
    apb(1'b0, SWT_ADDR_CNT, 32'h0);
    cmp("cnt_stop", 32'h0, {31'h0, r > 32'h3});
    wrap_up();
  end
endmodule
